// >>> design/cop_xfer_seq.sv
// Core-side sequencer for coprocessor register transfers and absent trap
`timescale 1ns/1ps
module cop_xfer_seq (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_ce,
   input wire logic i_issue,
   input wire logic i_thumb,
   input wire logic i_irq_pending,
   input wire cop_xfer_pkg::cop_fetched_word_t i_fetched_word,
   input wire logic [31:0] i_next_fetch,
   input wire cop_xfer_pkg::resp_t i_decode_handshake,
   input wire cop_xfer_pkg::resp_t i_execute_handshake,
   input wire logic [31:0] i_cop_word,
   output logic o_ready,
   output logic o_active,
   output logic [31:0] o_fetch_addr,
   output logic o_fetched_word_req_n,
   output logic o_fetched_word_sequential,
   output logic o_data_req_n,
   output logic o_data_sequential,
   output logic [31:0] o_wdata,
   output logic o_pass,
   output logic o_late_abort_flag,
   output cop_xfer_pkg::wb_t o_wb,
   output logic o_undef,
   output logic o_abandon,
   output logic o_done
);

   // ************************************************************
   // State
   // ************************************************************
   typedef enum logic [3:0] {
      s_idle,
      s_wait,
      s_one,
      s_dbl1,
      s_dbl2,
      s_abs,
      s_vec1,
      s_vec2,
      s_vec3
   } state_t;

   state_t state_q, state_d;
   cop_xfer_pkg::cop_fetched_word_t fetched_word_q, fetched_word_d;
   logic [31:0] fetch_q, fetch_d;
   logic [31:0] wdata_q, wdata_d;
   cop_xfer_pkg::wb_t wb_q, wb_d;
   logic undef_q, undef_d;
   logic abandon_q, abandon_d;
   logic done_q, done_d;
   logic take;
   logic from_cop;
   cop_xfer_pkg::cyc_kind_t ikind, dkind;

   assign take = i_issue && !i_thumb && (state_q == s_idle);
   assign from_cop = (fetched_word_q.op == cop_xfer_pkg::move_from_cop) ||
                     (fetched_word_q.op == cop_xfer_pkg::move_double_from_cop);

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      state_d = state_q;
      fetched_word_d = fetched_word_q;
      fetch_d = fetch_q;
      wdata_d = wdata_q;
      wb_d = '0;
      undef_d = 1'b0;
      abandon_d = 1'b0;
      done_d = 1'b0;
      case (state_q)
         s_idle: begin
            if (take) begin
               fetched_word_d = i_fetched_word;
               fetch_d = i_next_fetch;
               wdata_d = i_fetched_word.rd_val;
               // first answer read on decode handshake
               case (i_decode_handshake)
                  cop_xfer_pkg::resp_last: state_d = s_one;
                  cop_xfer_pkg::resp_go: state_d = s_dbl1;
                  cop_xfer_pkg::resp_wait: state_d = s_wait;
                  default: state_d = s_abs;
               endcase
            end
         end
         s_wait: begin
            case (i_execute_handshake)
               cop_xfer_pkg::resp_last: state_d = s_one;
               cop_xfer_pkg::resp_go: state_d = s_dbl1;
               cop_xfer_pkg::resp_absent: begin
                  state_d = s_vec1;
                  fetch_d = cop_xfer_pkg::UNDEF_VECTOR;
                  undef_d = 1'b1;
               end
               default: begin
                  if (i_irq_pending) begin
                     state_d = s_idle;
                     abandon_d = 1'b1;
                  end
               end
            endcase
         end
         s_one: begin
            // one word into Rd, read side
            if (from_cop) begin
               wb_d = '{we: 1'b1, idx: fetched_word_q.rd_idx, data: i_cop_word};
            end
            state_d = s_idle;
            done_d = 1'b1;
         end
         s_dbl1: begin
            if (from_cop) begin
               wb_d = '{we: 1'b1, idx: fetched_word_q.rd_idx, data: i_cop_word};
            end
            wdata_d = fetched_word_q.rn_val;
            state_d = s_dbl2;
         end
         s_dbl2: begin
            if (from_cop) begin
               wb_d = '{we: 1'b1, idx: fetched_word_q.rn_idx, data: i_cop_word};
            end
            state_d = s_idle;
            done_d = 1'b1;
         end
         s_abs: begin
            // nobody claimed it, take undefined trap
            state_d = s_vec1;
            fetch_d = cop_xfer_pkg::UNDEF_VECTOR;
            undef_d = 1'b1;
         end
         s_vec1: begin
            state_d = s_vec2;
            fetch_d = 32'(fetch_q + cop_xfer_pkg::FETCH_STEP);
         end
         s_vec2: begin
            state_d = s_vec3;
            fetch_d = 32'(fetch_q + cop_xfer_pkg::FETCH_STEP);
         end
         s_vec3: begin
            state_d = s_idle;
         end
         default: begin
            state_d = s_idle;
         end
      endcase
   end

   // Clock enable freezes every flop, so a stalled core holds its place
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         state_q <= s_idle;
         fetched_word_q <= '0;
         fetch_q <= cop_xfer_pkg::WORD_RESET;
         wdata_q <= cop_xfer_pkg::WORD_RESET;
         wb_q <= '0;
         undef_q <= 1'b0;
         abandon_q <= 1'b0;
         done_q <= 1'b0;
      end else if (i_ce) begin
         state_q <= state_d;
         fetched_word_q <= fetched_word_d;
         fetch_q <= fetch_d;
         wdata_q <= wdata_d;
         wb_q <= wb_d;
         undef_q <= undef_d;
         abandon_q <= abandon_d;
         done_q <= done_d;
      end
   end

   // ************************************************************
   // Bus cycle kinds per state
   // ************************************************************
   always_comb begin
      ikind = cop_xfer_pkg::cyc_i;
      dkind = cop_xfer_pkg::cyc_i;
      o_pass = 1'b0;
      case (state_q)
         s_wait, s_abs: begin
            o_pass = 1'b1;
         end
         s_one: begin
            ikind = cop_xfer_pkg::cyc_s;
            dkind = cop_xfer_pkg::cyc_c;
            o_pass = 1'b1;
         end
         s_dbl1: begin
            dkind = cop_xfer_pkg::cyc_c;
            o_pass = 1'b1;
         end
         s_dbl2: begin
            ikind = cop_xfer_pkg::cyc_s;
            dkind = cop_xfer_pkg::cyc_c;
            o_pass = 1'b1;
         end
         s_vec1: begin
            ikind = cop_xfer_pkg::cyc_n;
         end
         s_vec2, s_vec3: begin
            ikind = cop_xfer_pkg::cyc_s;
         end
         default: begin
            ikind = cop_xfer_pkg::cyc_i;
         end
      endcase
   end

   bus_cycle_code u_icode (
      .i_kind(ikind),
      .o_req_n(o_fetched_word_req_n),
      .o_seq(o_fetched_word_sequential)
   );

   bus_cycle_code u_dcode (
      .i_kind(dkind),
      .o_req_n(o_data_req_n),
      .o_seq(o_data_sequential)
   );

   assign o_ready = (state_q == s_idle);
   assign o_active = (state_q != s_idle);
   assign o_fetch_addr = fetch_q;
   assign o_wdata = wdata_q;
   assign o_late_abort_flag = cop_xfer_pkg::LATE_ABORT_VALUE;
   assign o_wb = wb_q;
   assign o_undef = undef_q;
   assign o_abandon = abandon_q;
   assign o_done = done_q;

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rstn || !i_ce);

   mrc_one_word_a: assert property (
      (state_q == s_one && fetched_word_q.op == cop_xfer_pkg::move_from_cop) |=>
      (o_wb.we && o_wb.idx == $past(fetched_word_q.rd_idx) && o_wb.data == $past(i_cop_word)))
      else $error("single move did not write one word to Rd");

   read_side_a: assert property (
      o_wb.we |-> ($past(o_data_req_n) && $past(o_data_sequential)))
      else $error("writeback without preceding coprocessor cycle");

   abandon_irq_a: assert property (
      (state_q == s_wait && i_execute_handshake == cop_xfer_pkg::resp_wait &&
       i_irq_pending) |=> (o_abandon && o_ready && !o_pass))
      else $error("busy wait not abandoned on interrupt");

   thumb_block_a: assert property (
      (o_ready && i_thumb) |=> o_ready)
      else $error("coprocessor op issued in compressed state");

   mcr_data_a: assert property (
      (state_q == s_one && fetched_word_q.op == cop_xfer_pkg::move_to_cop) |->
      (o_wdata == fetched_word_q.rd_val && o_data_req_n && o_data_sequential))
      else $error("Rd not on write data in transfer cycle");

   move_double_from_cop_pair_a: assert property (
      (state_q == s_dbl1 && fetched_word_q.op == cop_xfer_pkg::move_double_from_cop) |=>
      (o_wb.idx == fetched_word_q.rd_idx) ##1 (o_wb.we && o_wb.idx == fetched_word_q.rn_idx))
      else $error("double move writeback order wrong");

   move_double_to_cop_order_a: assert property (
      (state_q == s_dbl1 && fetched_word_q.op == cop_xfer_pkg::move_double_to_cop) |->
      (o_wdata == fetched_word_q.rd_val) ##1 (o_wdata == fetched_word_q.rn_val))
      else $error("double store order not Rd then Rn");

   undef_trap_a: assert property (
      (take && i_decode_handshake == cop_xfer_pkg::resp_absent) |=> ##1 o_undef)
      else $error("undefined trap not taken");

   single_cycle_a: assert property (
      (take && i_decode_handshake == cop_xfer_pkg::resp_last) |=>
      (!o_fetched_word_req_n && o_fetched_word_sequential && o_pass && o_data_sequential) ##1 o_done)
      else $error("single transfer not one cycle");

   wait_idle_a: assert property (
      (state_q == s_wait) |-> (o_fetched_word_req_n && !o_fetched_word_sequential && o_data_req_n &&
      !o_data_sequential && o_pass && !o_late_abort_flag))
      else $error("buses not idle while waiting");

   double_cycles_a: assert property (
      (state_q == s_dbl1) |-> (o_data_req_n && o_data_sequential) ##1
      (o_data_req_n && o_data_sequential && !o_fetched_word_req_n) ##1 o_done)
      else $error("double transfer cycles wrong");

   vector_fetch_a: assert property (
      (take && i_decode_handshake == cop_xfer_pkg::resp_absent) |=> o_pass ##1
      (!o_pass && o_fetch_addr == 32'h0000_0004 && !o_fetched_word_req_n && !o_fetched_word_sequential)
      ##1 (o_fetch_addr == 32'h0000_0008 && o_fetched_word_sequential)
      ##1 (o_fetch_addr == 32'h0000_000C && o_fetched_word_sequential && o_data_req_n))
      else $error("absent vector fetch sequence wrong");

   late_absent_a: assert property (
      (state_q == s_wait && i_execute_handshake == cop_xfer_pkg::resp_absent) |=>
      (!o_pass && o_fetch_addr == 32'h0000_0004 && !o_fetched_word_req_n && o_undef))
      else $error("late absent did not start vector fetch");

   single_seen_c: cover property (take && i_decode_handshake == cop_xfer_pkg::resp_last);
   wait_then_go_c: cover property (state_q == s_wait ##1 state_q == s_dbl1);
   absent_seen_c: cover property (o_undef);
   abandon_seen_c: cover property (o_abandon);

endmodule

// >>> pkg/cop_xfer_pkg.sv
// Shared types and constants for the coprocessor register transfer sequencer
package cop_xfer_pkg;

   // ************************************************************
   // Handshake responses and instruction kinds
   // ************************************************************
   typedef enum logic [1:0] {
      resp_absent = 2'h0,
      resp_wait   = 2'h1,
      resp_go     = 2'h2,
      resp_last   = 2'h3
   } resp_t;

   typedef enum logic [1:0] {
      move_from_cop        = 2'h0,
      move_to_cop          = 2'h1,
      move_double_from_cop = 2'h2,
      move_double_to_cop   = 2'h3
   } cop_op_t;

   // Bus cycle kinds: N nonsequential, S sequential, I idle, C coprocessor
   typedef enum logic [1:0] {
      cyc_n,
      cyc_s,
      cyc_i,
      cyc_c
   } cyc_kind_t;

   // ************************************************************
   // Carriers
   // ************************************************************
   typedef struct packed {
      cop_op_t op;
      logic [3:0] rd_idx;
      logic [3:0] rn_idx;
      logic [31:0] rd_val;
      logic [31:0] rn_val;
   } cop_fetched_word_t;

   typedef struct packed {
      logic we;
      logic [3:0] idx;
      logic [31:0] data;
   } wb_t;

   // ************************************************************
   // Constants
   // ************************************************************
   localparam logic [31:0] UNDEF_VECTOR = 32'h0000_0004;
   localparam logic [31:0] FETCH_STEP = 32'h0000_0004;
   localparam logic [31:0] WORD_RESET = 32'h0000_0000;
   localparam logic [3:0] IDX_RESET = 4'h0;
   localparam logic LATE_ABORT_VALUE = 1'b0;

endpackage

// >>> design/bus_cycle_code.sv
// Encodes a bus cycle kind into request and sequential strobes
`timescale 1ns/1ps
module bus_cycle_code (
   input wire cop_xfer_pkg::cyc_kind_t i_kind,
   output logic o_req_n,
   output logic o_seq
);

   always_comb begin
      o_req_n = 1'b1;
      o_seq = 1'b0;
      case (i_kind)
         cop_xfer_pkg::cyc_n: begin
            o_req_n = 1'b0;
            o_seq = 1'b0;
         end
         cop_xfer_pkg::cyc_s: begin
            o_req_n = 1'b0;
            o_seq = 1'b1;
         end
         cop_xfer_pkg::cyc_c: begin
            o_req_n = 1'b1;
            o_seq = 1'b1;
         end
         default: begin
            o_req_n = 1'b1;
            o_seq = 1'b0;
         end
      endcase
   end

endmodule

// >>> tb/cop_model.sv
// Behavioural coprocessor that answers the sequencer's handshakes
`timescale 1ns/1ps
module cop_model #(
   parameter logic [31:0] WORD_A = 32'h1234_5678,
   parameter logic [31:0] WORD_B = 32'h9abc_def0
) (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_start,
   input wire logic i_active,
   input wire logic i_dc,
   input wire cop_xfer_pkg::resp_t i_first,
   input wire logic [7:0] i_waits,
   input wire cop_xfer_pkg::resp_t i_final,
   output cop_xfer_pkg::resp_t o_decode_handshake,
   output cop_xfer_pkg::resp_t o_execute_handshake,
   output logic [31:0] o_cop_word
);
   // ************************************************************
   // Response sequencing
   // ************************************************************
   logic [1:0] phase_q;
   logic [7:0] cnt_q;
   logic sel_q;
   logic [31:0] cur;

   // go then last, or wait then final
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         phase_q <= 2'h0;
         cnt_q <= 8'h00;
         sel_q <= 1'b0;
      end else if (i_start) begin
         sel_q <= 1'b0;
         cnt_q <= i_waits;
         phase_q <= (i_first == cop_xfer_pkg::resp_wait) ? 2'h1 :
                    (i_first == cop_xfer_pkg::resp_go) ? 2'h2 : 2'h0;
      end else begin
         if (i_dc) sel_q <= ~sel_q;
         // Abandoned instruction: stop answering at once
         if (phase_q == 2'h1 && (!i_active || cnt_q <= 8'h01))
            phase_q <= (i_active && i_final == cop_xfer_pkg::resp_go) ? 2'h2 : 2'h0;
         else if (phase_q == 2'h2)
            phase_q <= 2'h0;
         if (cnt_q != 8'h00) cnt_q <= cnt_q - 8'h01;
      end
   end

   // absent unless handling, first on decode
   // wait repeats until the final answer
   always_comb begin
      o_decode_handshake = i_start ? i_first : cop_xfer_pkg::resp_absent;
      o_execute_handshake = cop_xfer_pkg::resp_absent;
      if (phase_q == 2'h1 && i_active)
         o_execute_handshake = (cnt_q > 8'h01) ? cop_xfer_pkg::resp_wait : i_final;
      if (phase_q == 2'h2) o_execute_handshake = cop_xfer_pkg::resp_last;
      cur = sel_q ? WORD_B : WORD_A;
      // Outside data cycles show the inverse, so stale data is never mistaken
      o_cop_word = i_dc ? cur : ~cur;
   end
endmodule

// >>> tb/test_cop_xfer_seq.sv
// Self-checking testbench for the coprocessor transfer sequencer
`timescale 1ns/1ps
module test_cop_xfer_seq;
   localparam logic [1:0] KI = 2'h2;
   localparam logic [1:0] KS = 2'h1;
   localparam logic [1:0] KN = 2'h0;
   localparam logic [1:0] KC = 2'h3;
   localparam logic [3:0] RD = 4'h3;
   localparam logic [3:0] RN = 4'h7;
   localparam logic [31:0] VD = 32'h1111_2222;
   localparam logic [31:0] VN = 32'h3333_4444;
   localparam logic [31:0] W1 = 32'h1234_5678;
   localparam logic [31:0] W2 = 32'h9abc_def0;
   localparam logic [31:0] NF = 32'h0000_1000;

   logic i_clk, i_rstn, i_ce, i_issue, i_thumb, i_irq_pending;
   cop_xfer_pkg::cop_fetched_word_t i_fetched_word;
   cop_xfer_pkg::resp_t dec, exe, first, fin;
   logic [7:0] waits;
   logic [31:0] cword;
   logic o_ready, o_active, o_fetched_word_req_n, o_fetched_word_sequential, o_data_req_n;
   logic o_data_sequential, o_pass, o_late_abort_flag, o_undef, o_abandon, o_done;
   logic [31:0] o_fetch_addr, o_wdata;
   cop_xfer_pkg::wb_t o_wb;
   logic start;
   int fails = 0;
   int total_checks = 0;

   assign start = i_issue & o_ready & ~i_thumb & i_ce;

   cop_xfer_seq dut_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(i_ce), .i_issue(i_issue),
      .i_thumb(i_thumb), .i_irq_pending(i_irq_pending), .i_fetched_word(i_fetched_word),
      .i_next_fetch(NF), .i_decode_handshake(dec), .i_execute_handshake(exe),
      .i_cop_word(cword), .o_ready(o_ready), .o_active(o_active),
      .o_fetch_addr(o_fetch_addr), .o_fetched_word_req_n(o_fetched_word_req_n),
      .o_fetched_word_sequential(o_fetched_word_sequential), .o_data_req_n(o_data_req_n),
      .o_data_sequential(o_data_sequential), .o_wdata(o_wdata), .o_pass(o_pass),
      .o_late_abort_flag(o_late_abort_flag), .o_wb(o_wb), .o_undef(o_undef),
      .o_abandon(o_abandon), .o_done(o_done));

   cop_model #(.WORD_A(W1), .WORD_B(W2)) cop_u (.i_clk(i_clk), .i_rstn(i_rstn),
      .i_start(start), .i_active(o_active), .i_dc(o_data_req_n & o_data_sequential),
      .i_first(first), .i_waits(waits), .i_final(fin), .o_decode_handshake(dec),
      .o_execute_handshake(exe), .o_cop_word(cword));

   // ************************************************************
   // Shared tasks
   // ************************************************************
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic nx();
      @(posedge i_clk);
      #1;
   endtask

   // Offers one instruction; returns settled in the first state cycle
   task automatic issue(input cop_xfer_pkg::cop_op_t op, input cop_xfer_pkg::resp_t f,
                        input logic [7:0] w, input cop_xfer_pkg::resp_t fn);
      @(posedge i_clk);
      i_issue <= 1'b1;
      i_fetched_word <= {op, RD, RN, VD, VN};
      first <= f;
      waits <= w;
      fin <= fn;
      @(posedge i_clk);
      i_issue <= 1'b0;
      #1;
   endtask

   task automatic bus(input string n, input logic [1:0] ik, input logic [1:0] dk,
                      input logic p);
      chk({n, " fetched_word"}, {30'h0, o_fetched_word_req_n, o_fetched_word_sequential}, {30'h0, ik});
      chk({n, " data"}, {30'h0, o_data_req_n, o_data_sequential}, {30'h0, dk});
      chk({n, " pass"}, {31'h0, o_pass}, {31'h0, p});
   endtask

   // Vector fetch of the undefined trap, three cycles
   task automatic vec(input string n);
      for (int i = 0; i < 3; i++) begin
         bus(n, (i == 0) ? KN : KS, KI, 1'b0);
         chk({n, " addr"}, o_fetch_addr, 32'h0000_0004 * (i + 1));
         chk({n, " undef"}, {31'h0, o_undef}, (i == 0) ? 32'h1 : 32'h0);
         nx();
      end
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_mrc();
      issue(cop_xfer_pkg::move_from_cop, cop_xfer_pkg::resp_last, 8'h00,
            cop_xfer_pkg::resp_absent);
      bus("mrc", KS, KC, 1'b1);
      chk("mrc fetch", o_fetch_addr, NF);
      chk("late abort", {31'h0, o_late_abort_flag}, 32'h0);
      nx();
      chk("mrc wb", {26'h0, o_done, o_wb.we, o_wb.idx}, {26'h0, 2'h3, RD});
      chk("mrc word", o_wb.data, W1);
      $display("mrc test over");
   endtask

   task automatic t_mcr_wait();
      issue(cop_xfer_pkg::move_to_cop, cop_xfer_pkg::resp_wait, 8'h03,
            cop_xfer_pkg::resp_last);
      for (int i = 0; i < 3; i++) begin
         bus("mcr wait", KI, KI, 1'b1);
         nx();
      end
      bus("mcr xfer", KS, KC, 1'b1);
      chk("mcr wdata", o_wdata, VD);
      nx();
      chk("mcr done", {31'h0, o_done}, 32'h1);
      $display("mcr wait test over");
   endtask

   task automatic t_move_double_from_cop();
      cop_xfer_pkg::wb_t got [0:1];
      int n;
      n = 0;
      issue(cop_xfer_pkg::move_double_from_cop, cop_xfer_pkg::resp_go, 8'h00,
            cop_xfer_pkg::resp_absent);
      for (int i = 0; i < 5; i++) begin
         if (i < 2) bus("move_double_from_cop", (i == 0) ? KI : KS, KC, 1'b1);
         if (o_wb.we === 1'b1 && n < 2) got[n] = o_wb;
         if (o_wb.we === 1'b1) n++;
         nx();
      end
      chk("move_double_from_cop count", n, 32'h2);
      chk("move_double_from_cop idx", {24'h0, got[0].idx, got[1].idx}, {24'h0, RD, RN});
      chk("move_double_from_cop first", got[0].data, W1);
      chk("move_double_from_cop second", got[1].data, W2);
      $display("move_double_from_cop test over");
   endtask

   // Wait twice, then go: double move lands Rd then Rn
   task automatic t_move_double_from_cop_wait();
      issue(cop_xfer_pkg::move_double_from_cop, cop_xfer_pkg::resp_wait, 8'h02,
            cop_xfer_pkg::resp_go);
      bus("move_double_from_cop w1", KI, KI, 1'b1);
      nx();
      bus("move_double_from_cop w2", KI, KI, 1'b1);
      nx();
      bus("move_double_from_cop go c1", KI, KC, 1'b1);
      nx();
      bus("move_double_from_cop go c2", KS, KC, 1'b1);
      chk("move_double_from_cop go wb1", {26'h0, o_done, o_wb.we, o_wb.idx}, {26'h0, 2'h1, RD});
      chk("move_double_from_cop go word1", o_wb.data, W1);
      nx();
      chk("move_double_from_cop go wb2", {26'h0, o_done, o_wb.we, o_wb.idx}, {26'h0, 2'h3, RN});
      chk("move_double_from_cop go word2", o_wb.data, W2);
      $display("move_double_from_cop wait test over");
   endtask

   // Clock enable drops in the second cycle: everything must hold
   task automatic t_move_double_to_cop();
      issue(cop_xfer_pkg::move_double_to_cop, cop_xfer_pkg::resp_go, 8'h00,
            cop_xfer_pkg::resp_absent);
      bus("move_double_to_cop c1", KI, KC, 1'b1);
      chk("move_double_to_cop rd", o_wdata, VD);
      @(posedge i_clk);
      i_ce <= 1'b0;
      #1;
      bus("move_double_to_cop c2", KS, KC, 1'b1);
      chk("move_double_to_cop rn", o_wdata, VN);
      repeat (2) @(posedge i_clk);
      i_ce <= 1'b1;
      #1;
      bus("move_double_to_cop hold", KS, KC, 1'b1);
      chk("move_double_to_cop hold rn", o_wdata, VN);
      nx();
      chk("move_double_to_cop done", {31'h0, o_done}, 32'h1);
      $display("move_double_to_cop test over");
   endtask

   task automatic t_absent();
      issue(cop_xfer_pkg::move_from_cop, cop_xfer_pkg::resp_absent, 8'h00,
            cop_xfer_pkg::resp_absent);
      bus("absent c1", KI, KI, 1'b1);
      nx();
      vec("absent");
      issue(cop_xfer_pkg::move_to_cop, cop_xfer_pkg::resp_wait, 8'h02,
            cop_xfer_pkg::resp_absent);
      bus("late c1", KI, KI, 1'b1);
      nx();
      bus("late c2", KI, KI, 1'b1);
      nx();
      vec("late");
      $display("absent test over");
   endtask

   task automatic t_abandon();
      logic seen;
      seen = 1'b0;
      @(posedge i_clk);
      i_irq_pending <= 1'b1;
      issue(cop_xfer_pkg::move_from_cop, cop_xfer_pkg::resp_wait, 8'h14,
            cop_xfer_pkg::resp_last);
      for (int i = 0; i < 4; i++) begin
         seen = seen | (o_abandon === 1'b1);
         nx();
      end
      chk("abandon", {31'h0, seen}, 32'h1);
      chk("abandon wb", {31'h0, o_wb.we}, 32'h0);
      @(posedge i_clk);
      i_irq_pending <= 1'b0;
      #1;
      chk("abandon ready", {31'h0, o_ready}, 32'h1);
      $display("abandon test over");
   endtask

   task automatic t_thumb();
      @(posedge i_clk);
      i_thumb <= 1'b1;
      issue(cop_xfer_pkg::move_from_cop, cop_xfer_pkg::resp_last, 8'h00,
            cop_xfer_pkg::resp_absent);
      chk("thumb active", {30'h0, o_active, o_ready}, 32'h1);
      nx();
      chk("thumb wb", {30'h0, o_active, o_wb.we}, 32'h0);
      @(posedge i_clk);
      i_thumb <= 1'b0;
      $display("thumb test over");
   endtask

   // ************************************************************
   // Clock, reset, sequence and watchdog
   // ************************************************************
   initial begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end

   initial begin
      i_rstn = 1'b0;
      i_ce = 1'b1;
      i_issue = 1'b0;
      i_thumb = 1'b0;
      i_irq_pending = 1'b0;
      i_fetched_word = '0;
      first = cop_xfer_pkg::resp_absent;
      fin = cop_xfer_pkg::resp_absent;
      waits = 8'h00;
      repeat (4) @(posedge i_clk);
      i_rstn <= 1'b1;
      t_mrc();
      t_mcr_wait();
      t_move_double_from_cop();
      t_move_double_from_cop_wait();
      t_move_double_to_cop();
      t_absent();
      t_abandon();
      t_thumb();
      test_done();
   end

   // Whole run is about sixty cycles; this leaves ample margin
   initial begin
      repeat (2000) @(posedge i_clk);
      fails++;
      test_done();
   end
endmodule
